// [rtl/fine_res_pkg.sv]
// Purpose: shared constants and types for the fine resolution waveform block
// Assumes: one 10 MHz clock acting as the fast clock, peripheral rate is clk/4
// Notes:   byte addresses, one 32-bit word per register
package fine_res_pkg;

  localparam int          TIMER_COUNT   = 2;
  localparam int          ADDR_W        = 6;
  localparam int          CNT_W         = 16;
  localparam int          LSB_W         = 2;
  localparam int          SEL_W         = 2;
  localparam int          MODE_W        = 2;

  // register byte offsets
  localparam logic [5:0]  OFS_CONTROL   = 6'h00;
  localparam logic [5:0]  OFS_T0_BASE   = 6'h10;
  localparam logic [5:0]  OFS_T1_BASE   = 6'h20;
  localparam logic [3:0]  OFS_MODE      = 4'h0;
  localparam logic [3:0]  OFS_PERIOD    = 4'h4;
  localparam logic [3:0]  OFS_COMPARE   = 4'h8;
  localparam logic [3:0]  OFS_COUNT     = 4'hc;

  // reset values
  localparam logic [1:0]  SEL_RESET     = 2'h0;
  localparam logic [1:0]  MODE_RESET    = 2'h0;
  localparam logic [15:0] PERIOD_RESET  = 16'hffff;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;

  // mode field encodings
  localparam logic [1:0]  MODE_STOP     = 2'h0;
  localparam logic [1:0]  MODE_FREQ     = 2'h1;
  localparam logic [1:0]  MODE_SINGLE   = 2'h2;
  localparam logic [1:0]  MODE_DUAL     = 2'h3;

  // counter steps
  localparam logic [15:0] STEP_COARSE   = 16'h0001;
  localparam logic [15:0] STEP_FINE     = 16'h0004;
  localparam logic [1:0]  PHASE_LAST    = 2'h3;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } dir_e;

  typedef struct packed {
    logic [1:0]  mode;
    logic [15:0] period;
    logic [15:0] compare;
  } timer_cfg_s;

endpackage

// [rtl/waveform_resolution_extension.sv]
// Purpose: two small timers with a fine resolution output extension, Avalon-MM slave
// Assumes: clk is the fourfold-speed clock; peripheral cycle is a 1-of-4 enable
// Notes:   waveOut feeds the downstream dead-time or pattern logic unchanged
//
// Functional notes
// - when enabled, output edges are placed with four times finer resolution (two extra bits).
// - fine placement works in frequency, single-slope and dual-slope modes, feeding later logic.
// - a selected timer ignores its two low counter bits and steps by four each peripheral cycle.
// - wrap and coarse compare on the upper 14 bits happen at the peripheral rate.
// - the two low bits are counted and compared at the fast rate inside the cycle.
// - reading the count of a selected timer returns zero in its two low bits.
// - pulses shorter than one peripheral cycle are removed, so single- and dual-slope compare below four gives none.
// - control bits 7 to 2 read as zero and software writes them as zero.
// - the select field picks none, timer zero, timer one or both for fine mode.
// - any select bit raises portFineEnable for the whole port; each timer runs fine only when its own bit is set.
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
module waveform_resolution_extension (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic      [1:0]  waveOut,
  output logic             portFineEnable
);

  localparam int N = fine_res_pkg::TIMER_COUNT;

  function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = data[7:0];
    end
    if (be[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave and registers

  logic                            ack;
  logic                            next_ack;
  logic [31:0]                     next_readdata;
  logic [1:0]                      sel;
  logic [1:0]                      next_sel;
  fine_res_pkg::timer_cfg_s        cfg [N];
  fine_res_pkg::timer_cfg_s        next_cfg [N];
  logic [15:0]                     cnt [N];
  logic [15:0]                     next_cnt [N];
  fine_res_pkg::dir_e              dir [N];
  fine_res_pkg::dir_e              next_dir [N];
  logic [1:0]                      waveOutNext;
  logic [1:0]                      phase;
  logic [1:0]                      next_phase;
  logic                            periphEn;
  logic [1:0]                      runMode [N];
  logic [1:0]                      next_runMode [N];
  logic [N-1:0]                    runFine;
  logic [N-1:0]                    next_runFine;

  assign waitrequest = (read | write) & ~ack;

  always_comb begin
    logic [5:0]  base;
    logic [3:0]  ofs;
    base          = address & 6'h30;
    ofs           = address[3:0];
    next_ack      = (read | write) & ~ack;
    next_readdata = readdata;
    next_sel      = sel;
    for (int t = 0; t < N; t++) begin
      next_cfg[t] = cfg[t];
    end
    if (ack && write && address == fine_res_pkg::OFS_CONTROL && byteenable[0]) begin
      next_sel = writedata[1:0];
    end
    for (int t = 0; t < N; t++) begin
      if (ack && write && base == ((t == 0) ? fine_res_pkg::OFS_T0_BASE
                                                 : fine_res_pkg::OFS_T1_BASE)) begin
        case (ofs)
          fine_res_pkg::OFS_MODE: begin
            if (byteenable[0]) begin
              next_cfg[t].mode = writedata[1:0];
            end
          end
          fine_res_pkg::OFS_PERIOD: begin
            next_cfg[t].period = mergeLanes(cfg[t].period, writedata, byteenable);
          end
          fine_res_pkg::OFS_COMPARE: begin
            next_cfg[t].compare = mergeLanes(cfg[t].compare, writedata, byteenable);
          end
          default: begin
          end
        endcase
      end
    end
    if (next_ack && read) begin
      next_readdata = 32'h0000_0000;
      if (address == fine_res_pkg::OFS_CONTROL) begin
        next_readdata = {30'h0, sel};
      end
      for (int t = 0; t < N; t++) begin
        if (base == ((t == 0) ? fine_res_pkg::OFS_T0_BASE : fine_res_pkg::OFS_T1_BASE)) begin
          case (ofs)
            fine_res_pkg::OFS_MODE:    next_readdata = {30'h0, cfg[t].mode};
            fine_res_pkg::OFS_PERIOD:  next_readdata = {16'h0, cfg[t].period};
            fine_res_pkg::OFS_COMPARE: next_readdata = {16'h0, cfg[t].compare};
            fine_res_pkg::OFS_COUNT: begin
              next_readdata = {16'h0, cnt[t]};
              if (sel[t]) begin
                next_readdata[1:0] = 2'h0;
              end
            end
            default:                   next_readdata = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack      <= 1'b0;
      readdata <= 32'h0000_0000;
      sel      <= fine_res_pkg::SEL_RESET;
      for (int t = 0; t < N; t++) begin
        cfg[t] <= '{fine_res_pkg::MODE_RESET, fine_res_pkg::PERIOD_RESET,
                    fine_res_pkg::COMPARE_RESET};
      end
    end else begin
      ack      <= next_ack;
      readdata <= next_readdata;
      sel      <= next_sel;
      for (int t = 0; t < N; t++) begin
        cfg[t] <= next_cfg[t];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // peripheral-rate enable from the fast clock

  assign next_phase = phase + 2'h1;
  assign periphEn   = (phase == fine_res_pkg::PHASE_LAST);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 2'h0;
    end else begin
      phase <= next_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counters, coarse compare and fine edge placement

  assign portFineEnable = |sel;

  always_comb begin
    logic [15:0] step;
    logic [15:0] fineCnt;
    logic        isFine;
    logic        atTop;
    logic        match;
    step        = fine_res_pkg::STEP_COARSE;
    fineCnt     = 16'h0;
    isFine      = 1'b0;
    atTop       = 1'b0;
    match       = 1'b0;
    waveOutNext = waveOut;
    next_runFine = runFine;
    for (int t = 0; t < N; t++) begin
      next_cnt[t] = cnt[t];
      next_dir[t] = dir[t];
      // mode and fine select only change on a peripheral cycle boundary
      next_runMode[t] = periphEn ? cfg[t].mode : runMode[t];
      next_runFine[t] = periphEn ? (sel[t] & portFineEnable) : runFine[t];
      isFine      = runFine[t];
      step        = isFine ? fine_res_pkg::STEP_FINE : fine_res_pkg::STEP_COARSE;
      // fast-rate fine count: low bits come from the phase, mirrored on the way down
      fineCnt     = {cnt[t][15:2], (dir[t] == fine_res_pkg::DIR_DOWN) ? ~phase : phase};
      if (runMode[t] == fine_res_pkg::MODE_FREQ) begin
        atTop = (cnt[t][15:2] >= cfg[t].compare[15:2]);
        match = isFine ? (fineCnt == cfg[t].compare) : (periphEn && atTop);
      end else begin
        atTop = (cnt[t][15:2] >= cfg[t].period[15:2]);
        match = 1'b0;
      end
      if (!isFine) begin
        atTop = (runMode[t] == fine_res_pkg::MODE_FREQ) ? (cnt[t] >= cfg[t].compare)
                                                         : (cnt[t] >= cfg[t].period);
      end
      if (periphEn) begin
        case (runMode[t])
          fine_res_pkg::MODE_FREQ,
          fine_res_pkg::MODE_SINGLE: begin
            next_dir[t] = fine_res_pkg::DIR_UP;
            next_cnt[t] = atTop ? 16'h0 : cnt[t] + step;
          end
          fine_res_pkg::MODE_DUAL: begin
            if (dir[t] == fine_res_pkg::DIR_UP) begin
              next_dir[t] = atTop ? fine_res_pkg::DIR_DOWN : fine_res_pkg::DIR_UP;
              next_cnt[t] = atTop ? cnt[t] - step : cnt[t] + step;
            end else begin
              next_dir[t] = (cnt[t] < step + step) ? fine_res_pkg::DIR_UP
                                                   : fine_res_pkg::DIR_DOWN;
              next_cnt[t] = (cnt[t] < step) ? 16'h0 : cnt[t] - step;
            end
          end
          default: begin
            next_cnt[t] = 16'h0;
            next_dir[t] = fine_res_pkg::DIR_UP;
          end
        endcase
        if (isFine) begin
          next_cnt[t][1:0] = 2'h0;
        end
      end
      case (runMode[t])
        fine_res_pkg::MODE_FREQ: begin
          if (match) begin
            waveOutNext[t] = ~waveOut[t];
          end
        end
        fine_res_pkg::MODE_SINGLE,
        fine_res_pkg::MODE_DUAL: begin
          if (isFine) begin
            waveOutNext[t] = (fineCnt < cfg[t].compare)
                             & (cfg[t].compare[15:2] != 14'h0);
          end else begin
            waveOutNext[t] = (cnt[t] < cfg[t].compare);
          end
        end
        default: begin
          waveOutNext[t] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waveOut <= 2'h0;
      runFine <= '0;
      for (int t = 0; t < N; t++) begin
        cnt[t] <= 16'h0;
        dir[t] <= fine_res_pkg::DIR_UP;
        runMode[t] <= fine_res_pkg::MODE_RESET;
      end
    end else begin
      waveOut <= waveOutNext;
      runFine <= next_runFine;
      for (int t = 0; t < N; t++) begin
        cnt[t] <= next_cnt[t];
        dir[t] <= next_dir[t];
        runMode[t] <= next_runMode[t];
      end
    end
  end

endmodule

// [testbench/fine_res_assertions.sv]
// Purpose: port checker for the fine resolution waveform block
// Assumes: one clock, requests held until waitrequest is low
// Notes:   bound to every instance of the block
module fine_res_assertions (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [1:0]  waveOut,
  input wire logic        portFineEnable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  chk_wait_first: assert property (
    (read || write) && !$past(read || write) |-> waitrequest) else $error("no wait");
  chk_wait_bound: assert property (
    (read || write) |-> ##[0:1] !waitrequest) else $error("late answer");
  chk_answer_once: assert property (
    (read || write) && !waitrequest |-> $past(waitrequest)) else $error("early answer");
  chk_sel_enable: assert property (
    write && !waitrequest && address == 6'h00 && byteenable[0]
    |=> portFineEnable == (|writedata[1:0])) else $error("port enable wrong");
  chk_fine_latch: assert property (
    !$stable(portFineEnable) |-> $past(write && address == 6'h00)) else $error("enable moved");
  chk_ctrl_reserved: assert property (
    read && !waitrequest && address == 6'h00 |-> readdata[31:2] == 30'h0)
    else $error("reserved bits set");
  chk_pulse_width: assert property (
    $rose(waveOut[0]) |-> waveOut[0] [*4]) else $error("narrow pulse");
  chk_coarse_align: assert property (
    !portFineEnable && $changed(waveOut[0]) |=> $stable(waveOut[0]) [*3])
    else $error("coarse edge off grid");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind waveform_resolution_extension fine_res_assertions chk_u (
  .clk(clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .waveOut(waveOut), .portFineEnable(portFineEnable));

// [testbench/wave_sink.sv]
// Purpose: downstream waveform consumer, counts high cycles in a window
// Assumes: wave is sampled on every fast clock edge
// Notes:   clear restarts the window
module wave_sink (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clear,
  input  wire logic        wave,
  output logic      [15:0] highCount
);
  timeunit 1ns;
  timeprecision 1ns;
  // consumes the waveform as later dead-time or pattern logic would
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      highCount <= 16'h0;
    else if (clear)
      highCount <= 16'h0;
    else if (wave)
      highCount <= highCount + 16'h1;
  end
endmodule

// [testbench/waveform_resolution_extension_tb.sv]
// Purpose: register and waveform tests for the fine resolution block
// Assumes: clk is the fast clock, peripheral cycle is four clocks
// Notes:   high time is counted over whole waveform periods
module waveform_resolution_extension_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [5:0]  address = 6'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'h3;
  logic        clear = 1'b0;
  logic [31:0] readdata, q;
  logic        waitrequest, portFineEnable;
  logic [1:0]  waveOut;
  logic [15:0] highA, highB;
  logic [15:0] cmpTab [4] = '{16'h3, 16'h5, 16'h6, 16'h7};
  int          badCount = 0;
  int          totalChecks = 0;
  int          cycles = 0;
  waveform_resolution_extension dut_u (.clk(clk), .arst_n(arst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .waveOut(waveOut),
    .portFineEnable(portFineEnable));
  wave_sink sinkA (.clk(clk), .arst_n(arst_n), .clear(clear), .wave(waveOut[0]),
    .highCount(highA));
  wave_sink sinkB (.clk(clk), .arst_n(arst_n), .clear(clear), .wave(waveOut[1]),
    .highCount(highB));
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #50 clk = ~clk; // fast clock only
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      badCount++;
      giveVerdict();
    end
  end
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic setupTimer(input logic [5:0] b, input logic [1:0] m, input logic [15:0] c);
    bus(1'b1, b, 32'h0);
    bus(1'b1, b + 6'h4, 32'h10); // period low bits kept zero
    bus(1'b1, b + 6'h8, {16'h0, c});
    bus(1'b1, b, {30'h0, m});
    repeat (48) @(posedge clk);
  endtask
  task automatic measure(input int w);
    @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    repeat (w) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    bus(1'b0, 6'h00, 32'h0);
    check(q, 32'h0, "select reset");
    bus(1'b0, 6'h14, 32'h0);
    check(q, 32'hffff, "period reset");
    bus(1'b1, 6'h30, 32'h5);
    bus(1'b0, 6'h30, 32'h0);
    check(q, 32'h0, "unmapped");
    bus(1'b1, 6'h00, 32'hff);
    bus(1'b0, 6'h00, 32'h0);
    check(q, 32'h3, "control readback");
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 6'h00, 32'(s));
      bus(1'b0, 6'h00, 32'h0);
      check(q, 32'(s), "select");
      check({31'h0, portFineEnable}, 32'(s != 0), "port enable");
    end
    $display("test registers done");
    bus(1'b1, 6'h00, 32'h0);
    setupTimer(6'h10, fine_res_pkg::MODE_SINGLE, 16'h8);
    measure(136);
    check({16'h0, highA}, 32'd64, "coarse high");
    $display("test coarse done");
    bus(1'b1, 6'h00, 32'h1);
    for (int i = 0; i < 4; i++) begin
      setupTimer(6'h10, fine_res_pkg::MODE_SINGLE, cmpTab[i]);
      measure(40);
      check({16'h0, highA}, (cmpTab[i] < 4) ? 32'h0 : 32'(2 * cmpTab[i]), "fine high");
      bus(1'b0, 6'h1c, 32'h0);
      check({30'h0, q[1:0]}, 32'h0, "count low bits");
    end
    $display("test fine single done");
    setupTimer(6'h10, fine_res_pkg::MODE_FREQ, 16'h8);
    measure(72);
    check({16'h0, highA}, 32'd36, "freq output");
    setupTimer(6'h10, fine_res_pkg::MODE_DUAL, 16'h8);
    measure(64);
    check({16'h0, highA}, 32'd24, "dual output");
    setupTimer(6'h10, fine_res_pkg::MODE_DUAL, 16'h2);
    measure(80);
    check({16'h0, highA}, 32'h0, "dual narrow");
    $display("test modes done");
    bus(1'b1, 6'h00, 32'h2);
    setupTimer(6'h20, fine_res_pkg::MODE_SINGLE, 16'h6);
    measure(40);
    check({16'h0, highB}, 32'd12, "timer one fine");
    $display("test timer one done");
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    bus(1'b0, 6'h00, 32'h0);
    check(q, 32'h0, "select after reset");
    check({31'h0, portFineEnable}, 32'h0, "enable after reset");
    $display("test second reset done");
    giveVerdict();
  end
endmodule
